// ==== inc/dsr_pkg.sv ====
// shared constants for the double-data-rate sram device end and its controller end
package dsr_pkg;

  // ----------------------------------------------------------------
  // organisation
  // ----------------------------------------------------------------
  localparam int DW       = 8;                      // data word width: 8, 9, 18 or 36
  localparam int NLANE    = (DW == 8) ? 2 : (DW == 9) ? 1 : (DW == 18) ? 2 : 4;
  localparam int LW       = DW / NLANE;             // bits governed by one write mask
  localparam int AW       = (DW <= 9) ? 22 : (DW == 18) ? 21 : 20; // RULE_08
  localparam int CORE_AW  = 10;                     // implemented depth, low address bits only
  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // input timing phases and reset values
  // ----------------------------------------------------------------
  localparam logic PH_POS = 1'b0;                   // rising edge of positive input phase
  localparam logic PH_NEG = 1'b1;                   // rising edge of negative input phase
  localparam logic SEL_IDLE = 1'b1;                 // active-low selects at rest
  localparam logic [NLANE-1:0] MASK_IDLE = {NLANE{1'b1}};

  // write command as it sits in the fifo: address, two words, two mask sets
  typedef struct packed {
    logic [AW-1:0]    addr;
    logic [DW-1:0]    data1;
    logic [NLANE-1:0] mask1_n;
    logic [DW-1:0]    data0;
    logic [NLANE-1:0] mask0_n;
  } dsr_wcmd_s;

  localparam int WCMD_W = $bits(dsr_wcmd_s);

endpackage : dsr_pkg

// ==== inc/dsr_if.sv ====
// pin-level link between the sram device end and the memory controller end
`timescale 1ns/100ps
interface dsr_if;
  logic                        k_phase;          // phase of the edge sampling the pins
  logic                        read_port_select; // active low
  logic                        write_port_select;// active low
  logic [dsr_pkg::AW-1:0]      addr;             // read addr on pos phase, write on neg
  logic [dsr_pkg::DW-1:0]      wdata;
  logic [dsr_pkg::NLANE-1:0]   write_mask_n;     // half-byte or byte lane masks
  logic [dsr_pkg::DW-1:0]      rdata;
  logic                        rdata_oe;         // high while the device drives rdata

  modport dev (
    input  k_phase,
    input  read_port_select,
    input  write_port_select,
    input  addr,
    input  wdata,
    input  write_mask_n,
    output rdata,
    output rdata_oe
  );

  modport ctrl (
    output k_phase,
    output read_port_select,
    output write_port_select,
    output addr,
    output wdata,
    output write_mask_n,
    input  rdata,
    input  rdata_oe
  );
endinterface : dsr_if

// ==== design/dsr_device.sv ====
// device end: burst-of-two sram with masked writes and double-rate read port
`timescale 1ns/100ps
module dsr_device (
  input  wire logic SYS_CLK,
  input  wire logic SYS_RST,
  dsr_if.dev        LINK
);

  // ----------------------------------------------------------------
  // write capture
  // ----------------------------------------------------------------
  logic                         wr_pend_reg;
  logic [dsr_pkg::DW-1:0]       wdata0_reg;
  logic [dsr_pkg::NLANE-1:0]    wmask0_n_reg;
  logic                         do_write;
  logic [dsr_pkg::CORE_AW-1:0]  waddr;

  // a write is committed at the negative phase that follows its select
  assign do_write = wr_pend_reg && (LINK.k_phase == dsr_pkg::PH_NEG);
  assign waddr    = LINK.addr[dsr_pkg::CORE_AW-1:0];                       // RULE_06

  // first word and its masks are held until the write address arrives
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      wr_pend_reg  <= 1'b0;
      wdata0_reg   <= '0;
      wmask0_n_reg <= dsr_pkg::MASK_IDLE;
    end
    else if (LINK.k_phase == dsr_pkg::PH_POS)
    begin
      wr_pend_reg <= (LINK.write_port_select == 1'b0);                    // RULE_13
      if (LINK.write_port_select == 1'b0)                                 // RULE_14
      begin
        wdata0_reg   <= LINK.wdata;                                       // RULE_16
        wmask0_n_reg <= LINK.write_mask_n;                                // RULE_03
      end
    end
    else
    begin
      wr_pend_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read sequencing
  // ----------------------------------------------------------------
  logic                         rd_pend_reg;
  logic                         rd_second_reg;
  logic [dsr_pkg::CORE_AW-1:0]  raddr_reg;
  logic                         rdata_oe_reg;

  // read address only taken while the read port is selected
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rd_pend_reg <= 1'b0;
      raddr_reg   <= '0;
    end
    else if (LINK.k_phase == dsr_pkg::PH_POS)
    begin
      rd_pend_reg <= (LINK.read_port_select == 1'b0);                     // RULE_15
      if (LINK.read_port_select == 1'b0)                                  // RULE_09
        raddr_reg <= LINK.addr[dsr_pkg::CORE_AW-1:0];                     // RULE_06
    end
  end

  // word 0 leaves on the negative phase, word 1 on the next positive phase;
  // a deselect only floats the bus after the pending burst is out
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      rd_second_reg <= 1'b0;
      rdata_oe_reg  <= 1'b0;
    end
    else if (LINK.k_phase == dsr_pkg::PH_NEG)
    begin
      rd_second_reg <= rd_pend_reg;
      rdata_oe_reg  <= rd_pend_reg;                                       // RULE_11
    end
    else
    begin
      rd_second_reg <= 1'b0;
      rdata_oe_reg  <= rd_second_reg;                                     // RULE_15
    end
  end

  // ----------------------------------------------------------------
  // storage and data path, one slice per mask lane
  // ----------------------------------------------------------------
  logic [dsr_pkg::DW-1:0] rdata_word;

  // x8 gives two half-byte lanes, wider words nine-bit byte lanes
  for (genvar g = 0; g < dsr_pkg::NLANE; g++)
  begin : g_lane
    logic [dsr_pkg::LW-1:0] mem_even [0:(1<<dsr_pkg::CORE_AW)-1];
    logic [dsr_pkg::LW-1:0] mem_odd  [0:(1<<dsr_pkg::CORE_AW)-1];
    logic [dsr_pkg::LW-1:0] lane_q_reg;

    // masked lanes are simply not written, so old contents survive
    always_ff @(posedge SYS_CLK)
    begin
      if (do_write && !wmask0_n_reg[g])                                   // RULE_04
        mem_even[waddr] <= wdata0_reg[g*dsr_pkg::LW +: dsr_pkg::LW];      // RULE_02
      if (do_write && !LINK.write_mask_n[g])                              // RULE_05
        mem_odd[waddr] <= LINK.wdata[g*dsr_pkg::LW +: dsr_pkg::LW];       // RULE_01
    end

    // single clock domain: both launches ride the input phases
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
      if (SYS_RST)
        lane_q_reg <= '0;
      else if (LINK.k_phase == dsr_pkg::PH_NEG && rd_pend_reg)
        lane_q_reg <= mem_even[raddr_reg];                                // RULE_10
      else if (LINK.k_phase == dsr_pkg::PH_POS && rd_second_reg)
        lane_q_reg <= mem_odd[raddr_reg];                                 // RULE_10
    end

    // each lane owns its slice, so every bit of the word has one driver
    assign rdata_word[g*dsr_pkg::LW +: dsr_pkg::LW] = lane_q_reg;
  end

  assign LINK.rdata    = rdata_word;                                      // RULE_12
  assign LINK.rdata_oe = rdata_oe_reg;

endmodule : dsr_device

// ==== design/dsr_ctrl.sv ====
// controller end: write command fifo and pin sequencer for the sram link
//
// How it works
// RULE_01 - x8 uses two active-low half-byte masks
// RULE_02 - first mask bits 3:0, second 7:4
// RULE_03 - masks sampled on same edge as data
// RULE_04 - deasserted mask leaves stored lane unchanged
// RULE_05 - wider words use up to four byte masks
// RULE_06 - read address positive phase, write address negative
// RULE_07 - controller alternates read and write addresses
// RULE_08 - address width 22, 21 or 20 bits
// RULE_09 - address ignored when its port deselected
// RULE_10 - read data launched on both phases
// RULE_11 - read outputs released when read deselected
// RULE_12 - read data width follows configuration
// RULE_13 - write select low on positive phase starts write
// RULE_14 - write data sampled only during writes
// RULE_15 - read select starts read; pending read completes
// RULE_16 - two-word burst, positive then negative phase
`timescale 1ns/100ps
module dsr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0]   count_reg;
  logic [PW:0]   count_next;
  logic          push;
  logic          pop;
  logic          full_reg;

  assign push       = in_valid && !full_reg;
  assign pop        = out_valid && out_ready;
  assign count_next = count_reg + (PW+1)'(push) - (PW+1)'(pop);
  assign in_ready   = !full_reg;
  assign out_valid  = (count_reg != '0);
  assign out_data   = mem[rd_ptr_reg];

  // storage, no reset needed for data
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  // pointers wrap naturally since depth is a power of two
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      full_reg   <= 1'b0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + PW'(push);
      rd_ptr_reg <= rd_ptr_reg + PW'(pop);
      count_reg  <= count_next;
      full_reg   <= (count_next == (PW+1)'(DEPTH));
    end
  end
endmodule : dsr_fifo

module dsr_ctrl (
  input  wire logic                            SYS_CLK,
  input  wire logic                            SYS_RST,
  input  wire logic                            WR_VALID,
  output logic                                 WR_READY,
  input  wire logic [dsr_pkg::WCMD_W-1:0]      WR_CMD,
  input  wire logic                            RD_VALID,
  output logic                                 RD_READY,
  input  wire logic [dsr_pkg::AW-1:0]          RD_ADDR,
  output logic                                 RD_DATA_VALID,
  output logic [2*dsr_pkg::DW-1:0]             RD_DATA,
  dsr_if.ctrl                                  LINK
);

  // ----------------------------------------------------------------
  // write buffering
  // ----------------------------------------------------------------
  logic                  phase_reg;
  logic                  fifo_valid;
  logic                  fifo_pop;
  dsr_pkg::dsr_wcmd_s    fifo_cmd;
  logic                  fifo_ready;
  localparam int CNT_W = $clog2(dsr_pkg::FIFO_DEPTH) + 1;
  logic [CNT_W-1:0]      wr_cnt_reg;
  logic [CNT_W-1:0]      wr_cnt_next;
  logic                  wr_push;

  // a write leaves the fifo only when a positive-phase slot is being set up
  assign fifo_pop = (phase_reg == dsr_pkg::PH_NEG);

  // only commands offered while ready are taken, so none is ever dropped
  assign wr_push     = WR_VALID && WR_READY && fifo_ready;
  assign wr_cnt_next = wr_cnt_reg + CNT_W'(wr_push) - CNT_W'(fifo_valid && fifo_pop);

  dsr_fifo #(
    .W     (dsr_pkg::WCMD_W),
    .DEPTH (dsr_pkg::FIFO_DEPTH)
  ) u_wfifo (
    .clk       (SYS_CLK),
    .rst       (SYS_RST),
    .in_valid  (wr_push),
    .in_ready  (fifo_ready),
    .in_data   (WR_CMD),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_cmd)
  );

  // occupancy mirror lets the flopped ready look one push ahead of full
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      wr_cnt_reg <= '0;
      WR_READY   <= 1'b0;
    end
    else
    begin
      wr_cnt_reg <= wr_cnt_next;
      WR_READY   <= (wr_cnt_next != CNT_W'(dsr_pkg::FIFO_DEPTH));
    end
  end

  // ----------------------------------------------------------------
  // pin sequencer
  // ----------------------------------------------------------------
  logic                      wr_hold_reg;
  dsr_pkg::dsr_wcmd_s        wr_cmd_reg;
  logic                      rd_take;

  assign rd_take = RD_VALID && RD_READY;

  // pins set at one edge are sampled by the device at the next one,
  // with k_phase naming that sampling edge
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      phase_reg              <= dsr_pkg::PH_POS;
      RD_READY               <= 1'b0;
      wr_hold_reg            <= 1'b0;
      wr_cmd_reg             <= '0;
      LINK.read_port_select  <= dsr_pkg::SEL_IDLE;
      LINK.write_port_select <= dsr_pkg::SEL_IDLE;
      LINK.addr              <= '0;
      LINK.wdata             <= '0;
      LINK.write_mask_n      <= dsr_pkg::MASK_IDLE;
    end
    else if (phase_reg == dsr_pkg::PH_NEG)
    begin
      // set up the positive phase: read address, write select and word 0
      phase_reg              <= dsr_pkg::PH_POS;
      RD_READY               <= 1'b0;
      LINK.read_port_select  <= !rd_take;                                 // RULE_15
      LINK.addr              <= rd_take ? RD_ADDR : '0;                   // RULE_07
      LINK.write_port_select <= !fifo_valid;                              // RULE_13
      wr_hold_reg            <= fifo_valid;
      wr_cmd_reg             <= fifo_cmd;
      LINK.wdata             <= fifo_valid ? fifo_cmd.data0 : '0;         // RULE_16
      LINK.write_mask_n      <= fifo_valid ? fifo_cmd.mask0_n : dsr_pkg::MASK_IDLE; // RULE_03
    end
    else
    begin
      // set up the negative phase: write address, word 1 and its masks
      phase_reg              <= dsr_pkg::PH_NEG;
      RD_READY               <= 1'b1;
      LINK.read_port_select  <= dsr_pkg::SEL_IDLE;
      LINK.write_port_select <= dsr_pkg::SEL_IDLE;
      LINK.addr              <= wr_hold_reg ? wr_cmd_reg.addr : '0;       // RULE_07
      LINK.wdata             <= wr_hold_reg ? wr_cmd_reg.data1 : '0;      // RULE_16
      LINK.write_mask_n      <= wr_hold_reg ? wr_cmd_reg.mask1_n : dsr_pkg::MASK_IDLE; // RULE_01
    end
  end

  assign LINK.k_phase = phase_reg;

  // ----------------------------------------------------------------
  // read capture
  // ----------------------------------------------------------------
  logic                   half_reg;

  // the device drives word 0 then word 1 back to back while enabled
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      half_reg      <= 1'b0;
      RD_DATA       <= '0;
      RD_DATA_VALID <= 1'b0;
    end
    else
    begin
      RD_DATA_VALID <= LINK.rdata_oe && half_reg;
      if (LINK.rdata_oe)
      begin
        half_reg <= !half_reg;
        if (half_reg)
          RD_DATA[2*dsr_pkg::DW-1:dsr_pkg::DW] <= LINK.rdata;
        else
          RD_DATA[dsr_pkg::DW-1:0] <= LINK.rdata;
      end
      else
      begin
        half_reg <= 1'b0;
      end
    end
  end

endmodule : dsr_ctrl

// ==== verification/dsr_properties.sv ====
// concurrent checks on the sram link between controller end and device end
`timescale 1ns/100ps
module dsr_properties (
  input wire logic                      SYS_CLK,
  input wire logic                      SYS_RST,
  input wire logic                      k_phase,
  input wire logic                      read_port_select,
  input wire logic                      write_port_select,
  input wire logic [dsr_pkg::AW-1:0]    addr,
  input wire logic [dsr_pkg::DW-1:0]    wdata,
  input wire logic [dsr_pkg::NLANE-1:0] write_mask_n,
  input wire logic [dsr_pkg::DW-1:0]    rdata,
  input wire logic                      rdata_oe
);
  // ----------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  // selects only count on the positive phase
  logic rd_req;
  logic wr_req;
  assign rd_req = !read_port_select && (k_phase == dsr_pkg::PH_POS);
  assign wr_req = !write_port_select && (k_phase == dsr_pkg::PH_POS);

  sequence s_rd_req; rd_req; endsequence
  sequence s_burst; rdata_oe [*2]; endsequence

  // first edge after release still shows the reset phase, so skip it
  property p_phase_alt; !$fell(SYS_RST) |-> k_phase != $past(k_phase); endproperty
  property p_rd_burst; s_rd_req |-> ##2 s_burst; endproperty
  property p_oe_cause; rdata_oe |-> $past(rd_req, 2) || $past(rd_req, 3); endproperty
  property p_oe_align; $rose(rdata_oe) |-> k_phase == dsr_pkg::PH_POS; endproperty
  property p_rd_release; s_rd_req ##2 read_port_select |-> ##2 !rdata_oe; endproperty
  property p_wr_burst; wr_req |=> (k_phase == dsr_pkg::PH_NEG) && write_port_select; endproperty
  property p_idle_addr; (k_phase == dsr_pkg::PH_POS) && read_port_select |-> addr == '0; endproperty
  property p_reset_exit;
    $fell(SYS_RST) |-> (!k_phase && !rdata_oe && read_port_select && write_port_select)
      ##1 (k_phase == dsr_pkg::PH_NEG);
  endproperty

  a_phase_alt : assert property (p_phase_alt)
    else $error("link phase did not alternate");
  a_rd_burst : assert property (p_rd_burst)
    else $error("read burst not driven for two phases");
  a_oe_cause : assert property (p_oe_cause)
    else $error("read data driven without a read");
  a_oe_align : assert property (p_oe_align)
    else $error("first read word not on positive phase");
  a_rd_release : assert property (p_rd_release)
    else $error("read data not released after burst");
  a_wr_burst : assert property (p_wr_burst)
    else $error("write burst second phase wrong");
  a_idle_addr : assert property (p_idle_addr)
    else $error("address not idle on deselected read phase");
  a_reset_exit : assert property (p_reset_exit)
    else $error("link pins wrong around reset release");
endmodule : dsr_properties

// ==== verification/test_ddr_sram_mask_addr_read_port.sv ====
// self-checking bench: controller end and device end joined over the sram link
`timescale 1ns/100ps
module test_ddr_sram_mask_addr_read_port;
  logic                       sys_clk;
  logic                       sys_rst;
  logic                       wr_valid;
  logic                       wr_ready;
  logic [dsr_pkg::WCMD_W-1:0] wr_cmd;
  logic                       rd_valid;
  logic                       rd_ready;
  logic [dsr_pkg::AW-1:0]     rd_addr;
  logic                       rd_data_valid;
  logic [2*dsr_pkg::DW-1:0]   rd_data;
  logic [dsr_pkg::DW-1:0]     mem [int];   // model words, index 2*location+word
  logic [2*dsr_pkg::DW-1:0]   exp_q [$];
  int                         bad_count;
  int                         num_checks;
  int                         seed;

  dsr_if dsr_if_i ();
  dsr_device dsr_device_i (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .LINK(dsr_if_i));
  dsr_ctrl dsr_ctrl_i (
    .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .WR_VALID(wr_valid), .WR_READY(wr_ready),
    .WR_CMD(wr_cmd), .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_ADDR(rd_addr),
    .RD_DATA_VALID(rd_data_valid), .RD_DATA(rd_data), .LINK(dsr_if_i));
  dsr_properties dsr_properties_i (
    .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .k_phase(dsr_if_i.k_phase),
    .read_port_select(dsr_if_i.read_port_select),
    .write_port_select(dsr_if_i.write_port_select), .addr(dsr_if_i.addr),
    .wdata(dsr_if_i.wdata), .write_mask_n(dsr_if_i.write_mask_n),
    .rdata(dsr_if_i.rdata), .rdata_oe(dsr_if_i.rdata_oe));

  // ----------------------------------------------------------------
  // clock, helpers and model
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [2*dsr_pkg::DW-1:0] got, input logic [2*dsr_pkg::DW-1:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // masked lanes keep the old contents
  function automatic logic [dsr_pkg::DW-1:0] merge(input logic [dsr_pkg::DW-1:0] old,
    input logic [dsr_pkg::DW-1:0] d, input logic [dsr_pkg::NLANE-1:0] m_n);
    merge = old;
    for (int l = 0; l < dsr_pkg::NLANE; l++)
      if (!m_n[l])
        merge[l*dsr_pkg::LW +: dsr_pkg::LW] = d[l*dsr_pkg::LW +: dsr_pkg::LW];
  endfunction : merge

  // push one write; caller drops valid, so back-to-back pushes hold it high
  task automatic wr(input logic [dsr_pkg::AW-1:0] a, input logic [2*dsr_pkg::DW-1:0] d,
    input logic [dsr_pkg::NLANE-1:0] m0, input logic [dsr_pkg::NLANE-1:0] m1);
    int i;
    dsr_pkg::dsr_wcmd_s c;
    i = 2 * int'(a[dsr_pkg::CORE_AW-1:0]);
    mem[i] = merge(mem[i], d[dsr_pkg::DW-1:0], m0);
    mem[i+1] = merge(mem[i+1], d[2*dsr_pkg::DW-1:dsr_pkg::DW], m1);
    c = '{addr: a, data1: d[2*dsr_pkg::DW-1:dsr_pkg::DW], mask1_n: m1,
          data0: d[dsr_pkg::DW-1:0], mask0_n: m0};
    wr_valid = 1'b1;
    wr_cmd = c;
    while (wr_ready !== 1'b1)
      @(negedge sys_clk);
    @(negedge sys_clk);
  endtask : wr

  // request held until a ready edge takes it
  task automatic rd(input logic [dsr_pkg::AW-1:0] a);
    int i;
    i = 2 * int'(a[dsr_pkg::CORE_AW-1:0]);
    rd_valid = 1'b1;
    rd_addr = a;
    while (rd_ready !== 1'b1)
      @(negedge sys_clk);
    exp_q.push_back({mem[i+1], mem[i]});
    @(negedge sys_clk);
  endtask : rd

  // every returned burst against the model, word0 in the low half
  always @(negedge sys_clk)
    if (rd_data_valid === 1'b1)
      check(rd_data, exp_q.pop_front());

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial
  begin
    logic [dsr_pkg::AW-1:0] a [4];
    logic [dsr_pkg::AW-1:0] b;
    seed = 32'hde1fab63;
    bad_count = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    wr_valid = 1'b0;
    wr_cmd = '0;
    rd_valid = 1'b0;
    rd_addr = '0;
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    for (int r = 0; r < 8; r++)
    begin
      // four back-to-back full writes queue at most three deep in the four-entry fifo
      for (int k = 0; k < 4; k++)
      begin
        a[k] = dsr_pkg::AW'($random(seed));
        wr(a[k], (2*dsr_pkg::DW)'($random(seed)), '0, '0);
      end
      wr_valid = 1'b0;
      repeat (16) @(negedge sys_clk);
      // every mask pattern on both burst words
      for (int k = 0; k < 4; k++)
        wr(a[k], (2*dsr_pkg::DW)'($random(seed)), dsr_pkg::NLANE'(k), ~dsr_pkg::NLANE'(k));
      wr_valid = 1'b0;
      repeat (16) @(negedge sys_clk);
      // back-to-back reads; upper bits vary since only the core bits decode
      for (int k = 0; k < 4; k++)
      begin
        b = dsr_pkg::AW'($random(seed));
        b[dsr_pkg::CORE_AW-1:0] = a[k][dsr_pkg::CORE_AW-1:0];
        rd(b);
      end
      rd_valid = 1'b0;
      repeat (16) @(negedge sys_clk);
      $display("round %0d of masked writes and read bursts done", r);
    end
    check((2*dsr_pkg::DW)'(exp_q.size()), '0);
    tally_and_finish();
  end

  // hang guard, well beyond the few hundred cycles the rounds need
  initial
  begin
    repeat (4000) @(posedge sys_clk);
    bad_count++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule : test_ddr_sram_mask_addr_read_port
